// ==== bbpwm_consts.svh ====
// Timing counts, thresholds and fault codes of the balancer sequencer.
// Assumes a 50 MHz core clock; every cycle and watchdog count is derived from a time below.
`ifndef BBPWM_CONSTS_SVH
`define BBPWM_CONSTS_SVH

`define BB_CLK_PERIOD_NS 20
`define BB_SW_PERIOD_NS  4000
`define BB_SW_CYCLES     (`BB_SW_PERIOD_NS / `BB_CLK_PERIOD_NS)
`define BB_DEAD_NS       100
`define BB_DEAD_CYCLES   (`BB_DEAD_NS / `BB_CLK_PERIOD_NS)
`define BB_MAXON_NS      3200
`define BB_MAXON_CYCLES  (`BB_MAXON_NS / `BB_CLK_PERIOD_NS)
`define BB_HOLD_US       10
`define BB_HOLD_CYCLES   (`BB_HOLD_US * 1000 / `BB_CLK_PERIOD_NS)
`define BB_WD_S          8
`define BB_WD_PERIODS    (64'd`BB_WD_S * 64'd1000000000 / 64'd`BB_SW_PERIOD_NS)
`define BB_WD_W          22
`define BB_CL_WINDOW     32
`define BB_CL_PRI_MAX    4
`define BB_CL_SEC_MAX    8
`define BB_FIN_PCT       5
`define BB_SP_W          8
`define BB_IN_W          17

`define BB_ERR_NONE      3'h0
`define BB_ERR_CL_PRI    3'h1
`define BB_ERR_CL_SEC    3'h2
`define BB_ERR_THERMAL   3'h3
`define BB_ERR_WATCHDOG  3'h4
`define BB_ERR_UNDERV    3'h5
`define BB_ERR_OVERV     3'h6

`endif

// ==== bbpwm_pkg.sv ====
// Types shared by the balancer sequencer and its gate timing generator.
// Relies on the constants header for the input, level, watchdog and dead-time widths.
`include "bbpwm_consts.svh"

package bbpwm_pkg;

  typedef logic [2:0]             bbpwm_err_t;
  typedef logic [`BB_SP_W-1:0]    bbpwm_lvl_t;

  typedef enum logic [2:0]
  {
    ST_DONE   = 3'h0,
    ST_HOLD   = 3'h1,
    ST_ECHO   = 3'h2,
    ST_RUN    = 3'h3,
    ST_RAMPDN = 3'h4
  } bbpwm_state_t;

  typedef struct packed
  {
    logic [`BB_IN_W-1:0]  s1;
    logic [`BB_IN_W-1:0]  s2;
    logic                 en_p;
    logic                 ilp_p;
    logic                 ils_p;
    bbpwm_state_t         state;
    logic [7:0]           phase;
    logic [8:0]           hold;
    logic [`BB_WD_W-1:0]  wd;
    logic [4:0]           win;
    logic [3:0]           clp;
    logic [3:0]           cls;
    bbpwm_lvl_t           ramp;
    bbpwm_lvl_t           ref_lvl;
    logic                 finished;
    logic                 echo;
    bbpwm_err_t           err;
    logic                 sense;
    logic                 g_pri;
    logic                 g_sec1;
    logic                 g_sec2;
    logic                 g_clamp;
  } bbpwm_seq_t;

  typedef struct packed
  {
    logic                       ctrl;
    logic [`BB_DEAD_CYCLES-1:0] hist;
    logic                       g_pri;
    logic                       g_sec1;
    logic                       g_sec2;
    logic                       g_clamp;
  } bbpwm_tim_t;

endpackage

// ==== bbpwm_gate_if.sv ====
// Carrier between the sequencer and the gate timing generator.
// Both ends share one clock; nothing here is registered.
`timescale 1ns/1ps

interface bbpwm_gate_if;
  logic [7:0] phase;
  logic       run_ctrl;
  logic       run_sync;
  logic       polarity;
  logic       trip;
  logic       g_pri;
  logic       g_sec1;
  logic       g_sec2;
  logic       g_clamp;

  modport seq
  (
    output phase, run_ctrl, run_sync, polarity, trip,
    input  g_pri, g_sec1, g_sec2, g_clamp
  );

  modport tim
  (
    input  phase, run_ctrl, run_sync, polarity, trip,
    output g_pri, g_sec1, g_sec2, g_clamp
  );
endinterface

// ==== bbpwm_timing.sv ====
// Gate timing generator: one control pulse per switching period, with the
// synchronous gates timed from it. Inputs are already synchronised.
`timescale 1ns/1ps
`include "bbpwm_consts.svh"

module bbpwm_timing
(
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  bbpwm_gate_if.tim  gif
);
  import bbpwm_pkg::*;

  bbpwm_tim_t q;
  bbpwm_tim_t d;
  logic       hist_any;
  logic       rect;
  logic       sync;

  always_comb
  begin
    d        = q;
    hist_any = |q.hist;
    // Control pulse sets the duty cycle; it ends on the peak trip or at the maximum on-time.
    if (!gif.run_ctrl)
    begin
      d.ctrl = 1'b0;
    end
    else if (gif.phase == 8'(`BB_DEAD_CYCLES))
    begin
      d.ctrl = 1'b1;
    end
    else if (gif.trip || gif.phase == 8'(`BB_MAXON_CYCLES))
    begin
      d.ctrl = 1'b0;
    end
    d.hist = {q.hist[`BB_DEAD_CYCLES-2:0], q.ctrl};
    // Synchronous gates follow the control pulse with a dead time and are
    // kept off on their own enable so the sequencer can drop them first.
    rect = gif.run_sync & q.ctrl & q.hist[`BB_DEAD_CYCLES-1];
    sync = gif.run_sync & ~q.ctrl & ~hist_any
         & (gif.phase > 8'(`BB_DEAD_CYCLES));
    d.g_clamp = gif.run_ctrl & (q.ctrl | hist_any);
    if (gif.polarity)
    begin
      d.g_pri  = q.ctrl;
      d.g_sec1 = rect;
    end
    else
    begin
      d.g_pri  = rect;
      d.g_sec1 = q.ctrl;
    end
    d.g_sec2 = sync;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign gif.g_pri   = q.g_pri;
  assign gif.g_sec1  = q.g_sec1;
  assign gif.g_sec2  = q.g_sec2;
  assign gif.g_clamp = q.g_clamp;

endmodule

// ==== bbpwm_seq.sv ====
// Balancer converter sequencer: enable handshake, soft start and stop,
// fault latching, watchdog and gate output gating.
// Assumes every pin input is asynchronous to I_CLOCK.
`timescale 1ns/1ps
`include "bbpwm_consts.svh"

module bbpwm_seq
#(
  parameter int unsigned WD_PERIODS = 32'(`BB_WD_PERIODS)
)
(
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_NRST,
  input  wire logic                  I_ENABLE,
  input  wire logic                  I_POLARITY_SELECT,
  input  wire bbpwm_pkg::bbpwm_lvl_t I_CURRENT_SETPOINT_IN,
  input  wire logic                  I_PEAK_TRIP,
  input  wire logic                  I_ILIM_PRI,
  input  wire logic                  I_ILIM_SEC,
  input  wire logic                  I_OVERVOLT,
  input  wire logic                  I_UNDERVOLT,
  input  wire logic                  I_THERMAL,
  input  wire logic                  I_UNDERVOLTAGE_LOCKOUT_N,
  output logic                       O_CYCLE_FINISHED,
  output logic                       O_POLARITY_ECHO,
  output bbpwm_pkg::bbpwm_err_t      O_ERROR_CODE,
  output bbpwm_pkg::bbpwm_lvl_t      O_REFERENCE,
  output logic                       O_SENSE_INVERT,
  output logic                       O_GATE_PRI,
  output logic                       O_GATE_SEC1,
  output logic                       O_GATE_SEC2,
  output logic                       O_CLAMP_TIMING
);
  import bbpwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  bbpwm_seq_t  q;
  bbpwm_seq_t  d;
  bbpwm_gate_if gif ();

  logic        en_s, pol_s, trip_s, ilp_s, ils_s, ovp_s, uvp_s, therm_s, uv_ok;
  bbpwm_lvl_t  sp_s;
  bbpwm_lvl_t  thr;
  logic [15:0] thr_w;
  logic        tick, en_rise, fault;
  bbpwm_err_t  code;

  always_ff @(posedge I_CLOCK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign {sp_s, uv_ok, therm_s, uvp_s, ovp_s, ils_s, ilp_s, trip_s, pol_s,
          en_s} = q.s2;

  bbpwm_timing u_timing
  (
    .i_clk   (I_CLOCK),
    .i_rst_n (rst_n),
    .gif     (gif.tim)
  );

  assign gif.phase    = q.phase;
  assign gif.run_ctrl = uv_ok & (q.state == ST_RUN | q.state == ST_RAMPDN);
  // Synchronous gates drop at ramp-down so the rectifier cannot pull
  // current backwards while the reference falls.
  assign gif.run_sync = uv_ok & (q.state == ST_RUN);
  assign gif.polarity = pol_s;
  assign gif.trip     = trip_s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d       = q;
    d.s1    = {I_CURRENT_SETPOINT_IN, I_UNDERVOLTAGE_LOCKOUT_N, I_THERMAL,
               I_UNDERVOLT, I_OVERVOLT, I_ILIM_SEC, I_ILIM_PRI, I_PEAK_TRIP,
               I_POLARITY_SELECT, I_ENABLE};
    d.s2    = q.s1;
    d.en_p  = en_s;
    d.ilp_p = ilp_s;
    d.ils_p = ils_s;
    tick    = q.phase == 8'(`BB_SW_CYCLES - 1);
    en_rise = en_s & ~q.en_p;
    thr_w   = (16'(sp_s) * 16'(`BB_FIN_PCT)) / 16'd100;
    thr     = thr_w[7:0];
    d.phase = tick ? 8'h00 : q.phase + 8'h01;
    d.sense = pol_s;

    // Limit events per window of switching periods.
    if (ilp_s && !q.ilp_p && q.clp != 4'(`BB_CL_PRI_MAX))
    begin
      d.clp = q.clp + 4'h1;
    end
    if (ils_s && !q.ils_p && q.cls != 4'(`BB_CL_SEC_MAX))
    begin
      d.cls = q.cls + 4'h1;
    end
    if (tick)
    begin
      d.win = q.win + 5'h01;
      if (q.win == 5'(`BB_CL_WINDOW - 1))
      begin
        // An event on the window edge opens the count of the next window.
        d.clp = {3'h0, ilp_s & ~q.ilp_p};
        d.cls = {3'h0, ils_s & ~q.ils_p};
      end
    end

    // Fixed priority when several faults land together.
    fault = 1'b1;
    if (q.clp == 4'(`BB_CL_PRI_MAX))
      code = `BB_ERR_CL_PRI;
    else if (q.cls == 4'(`BB_CL_SEC_MAX))
      code = `BB_ERR_CL_SEC;
    else if (therm_s)
      code = `BB_ERR_THERMAL;
    else if (q.wd == `BB_WD_W'(WD_PERIODS))
      code = `BB_ERR_WATCHDOG;
    else if (uvp_s)
      code = `BB_ERR_UNDERV;
    else if (ovp_s)
      code = `BB_ERR_OVERV;
    else
    begin
      code  = `BB_ERR_NONE;
      fault = 1'b0;
    end

    unique case (q.state)
      ST_DONE:
      begin
        d.ramp = '0;
      end
      ST_HOLD:
      begin
        d.hold = q.hold + 9'h001;
        if (q.hold == 9'(`BB_HOLD_CYCLES - 1))
        begin
          d.state = ST_ECHO;
        end
      end
      ST_ECHO:
      begin
        d.echo  = ~pol_s;
        d.state = ST_RUN;
      end
      ST_RUN:
      begin
        if (tick && q.ramp < sp_s)
        begin
          d.ramp = q.ramp + 8'h01;
        end
        if (!en_s)
        begin
          d.state = ST_RAMPDN;
        end
      end
      ST_RAMPDN:
      begin
        if (q.ramp <= thr)
        begin
          d.state    = ST_DONE;
          d.finished = 1'b1;
          d.ramp     = '0;
        end
        else if (tick)
        begin
          d.ramp = q.ramp - 8'h01;
        end
      end
      default:
      begin
        d.state    = ST_DONE;
        d.finished = 1'b1;
      end
    endcase

    if (q.state == ST_RUN || q.state == ST_RAMPDN)
    begin
      if (tick && q.wd != `BB_WD_W'(WD_PERIODS))
      begin
        d.wd = q.wd + `BB_WD_W'(1);
      end
      if (fault)
      begin
        d.state    = ST_DONE;
        d.finished = 1'b1;
        d.err      = code;
        d.ramp     = '0;
      end
    end

    if (en_rise)
    begin
      d.state    = ST_HOLD;
      d.finished = 1'b0;
      d.err      = `BB_ERR_NONE;
      d.hold     = '0;
      d.wd       = '0;
      d.ramp     = '0;
      d.clp      = 4'h0;
      d.cls      = 4'h0;
    end

    d.ref_lvl = (q.ramp < sp_s) ? q.ramp : sp_s;
    d.g_pri   = uv_ok & gif.g_pri;
    d.g_sec1  = uv_ok & gif.g_sec1;
    d.g_sec2  = uv_ok & gif.g_sec2;
    d.g_clamp = uv_ok & gif.g_clamp;
  end

  always_ff @(posedge I_CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q          <= '0;
      q.state    <= ST_DONE;
      q.finished <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign O_CYCLE_FINISHED = q.finished;
  assign O_POLARITY_ECHO  = q.echo;
  assign O_ERROR_CODE     = q.err;
  assign O_REFERENCE      = q.ref_lvl;
  assign O_SENSE_INVERT   = q.sense;
  assign O_GATE_PRI       = q.g_pri;
  assign O_GATE_SEC1      = q.g_sec1;
  assign O_GATE_SEC2      = q.g_sec2;
  assign O_CLAMP_TIMING   = q.g_clamp;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!rst_n);

  sequence s_hold3;
    (q.state == ST_HOLD) [*3];
  endsequence

  sequence s_fin;
    q.state == ST_RAMPDN && q.ramp <= thr && !fault && !en_rise;
  endsequence

  AST_ACK: assert property (en_rise
                           |=> !q.finished && q.state == ST_HOLD)
    else $error("finished not lowered after enable rise");
  AST_ECHO: assert property (q.state == ST_ECHO && !en_rise
                            |=> q.echo == !$past(pol_s))
    else $error("polarity echo not inverse of polarity select");
  AST_HOLD: assert property (s_hold3 |-> !q.g_pri && !q.g_sec1
                            && !q.g_sec2 && !q.g_clamp)
    else $error("gate active during start hold");
  AST_DOWN: assert property (q.state == ST_RUN && !en_s && !en_rise
                            && !fault |=> q.state == ST_RAMPDN)
    else $error("ramp-down not started on enable low");
  AST_FIN: assert property (s_fin |=> q.finished ##1 q.finished)
    else $error("finished not raised at ramp end");
  AST_FAULT: assert property ((q.state == ST_RUN || q.state == ST_RAMPDN)
                             && fault && !en_rise
                             |=> q.finished && q.err == $past(code))
    else $error("fault did not latch code and finished");
  AST_UNDERVOLTAGE_LOCKOUT: assert property (!uv_ok |=> !q.g_pri && !q.g_sec1
                            && !q.g_sec2 && !q.g_clamp)
    else $error("gate on during undervoltage lockout");
  AST_LATCH: assert property (q.state == ST_DONE && !en_rise
                             |=> $stable(q.err) && q.finished)
    else $error("latched result changed without enable");
  AST_SENSE: assert property (##1 q.sense == $past(pol_s))
    else $error("sense polarity not following select");
  AST_REF: assert property (q.ref_lvl <= $past(sp_s) || $changed(sp_s)
                           || $past(sp_s) != $past(sp_s, 2))
    else $error("reference above set-point");
  AST_CLPRI: assert property (q.clp == 4'(`BB_CL_PRI_MAX)
                             && q.state == ST_RUN && !en_rise
                             |=> q.err == `BB_ERR_CL_PRI)
    else $error("primary limit count did not fault");

endmodule

// ==== bbpwm_partner.sv ====
// Model of the switch-matrix driver chip that sequences the converter.
// Assumes the bench calls start and stop; one clock, no reset of its own.
`timescale 1ns/1ps

module bbpwm_partner
(
  input  wire logic                  i_clk,
  input  wire logic                  i_finished,
  input  wire bbpwm_pkg::bbpwm_err_t i_err_code,
  output logic                       o_enable,
  output logic                       o_polarity,
  output logic                       o_error_irq,
  output bbpwm_pkg::bbpwm_err_t      o_code_seen
);
  import bbpwm_pkg::*;

  logic active_q;

  initial
  begin
    o_enable    = 1'b0;
    o_polarity  = 1'b0;
    o_error_irq = 1'b0;
    o_code_seen = 3'h0;
    active_q    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Finished rising while enable is still up can only be a fault stop.
  always @(posedge i_clk)
  begin
    if (o_enable && !i_finished)
      active_q <= 1'b1;
    if (o_enable && active_q && i_finished && !o_error_irq)
    begin
      o_error_irq <= 1'b1;
      o_code_seen <= i_err_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic start(input logic sel);
    @(posedge i_clk);
    o_enable    <= 1'b1;
    o_polarity  <= sel;
    o_error_irq <= 1'b0;
    active_q    <= 1'b0;
  endtask

  // A restart inside the watchdog span keeps a long balance going.
  task automatic stop();
    @(posedge i_clk);
    o_enable <= 1'b0;
  endtask
endmodule

// ==== tb_bidirectional_balancer_pwm_sequencer.sv ====
// Self-checking bench for the balancer sequencer with a partner model.
// Assumes a shortened watchdog span given through WD_PERIODS.
`timescale 1ns/1ps

module tb_bidirectional_balancer_pwm_sequencer;
  import bbpwm_pkg::*;

  localparam int unsigned WD_SIM = 50;

  logic       clk;
  logic       nrst;
  logic       enable;
  logic       polarity;
  logic       error_irq;
  bbpwm_err_t code_seen;
  bbpwm_lvl_t setpoint;
  logic       peak_trip;
  logic       ilim_pri;
  logic       ilim_sec;
  logic       overvolt;
  logic       undervolt;
  logic       thermal;
  logic       undervoltage_lockout_n;
  logic       finished;
  logic       echo;
  bbpwm_err_t err_code;
  bbpwm_lvl_t reference;
  logic       sense_inv;
  logic [3:0] gates;
  logic [3:0] gates_q;
  int         rises [4];
  int         failures;
  int         samples_checked;

  always #10 clk = ~clk;

  bbpwm_seq #(.WD_PERIODS(WD_SIM)) i_bbpwm_seq
  (
    .I_CLOCK                  (clk),
    .I_NRST                   (nrst),
    .I_ENABLE                 (enable),
    .I_POLARITY_SELECT        (polarity),
    .I_CURRENT_SETPOINT_IN    (setpoint),
    .I_PEAK_TRIP              (peak_trip),
    .I_ILIM_PRI               (ilim_pri),
    .I_ILIM_SEC               (ilim_sec),
    .I_OVERVOLT               (overvolt),
    .I_UNDERVOLT              (undervolt),
    .I_THERMAL                (thermal),
    .I_UNDERVOLTAGE_LOCKOUT_N (undervoltage_lockout_n),
    .O_CYCLE_FINISHED         (finished),
    .O_POLARITY_ECHO          (echo),
    .O_ERROR_CODE             (err_code),
    .O_REFERENCE              (reference),
    .O_SENSE_INVERT           (sense_inv),
    .O_GATE_PRI               (gates[0]),
    .O_GATE_SEC1              (gates[1]),
    .O_GATE_SEC2              (gates[2]),
    .O_CLAMP_TIMING           (gates[3])
  );

  bbpwm_partner i_bbpwm_partner
  (
    .i_clk       (clk),
    .i_finished  (finished),
    .i_err_code  (err_code),
    .o_enable    (enable),
    .o_polarity  (polarity),
    .o_error_irq (error_irq),
    .o_code_seen (code_seen)
  );

  // Rising edges are counted so that toggling can be judged over a span.
  always @(posedge clk)
  begin
    gates_q <= gates;
    for (int k = 0; k < 4; k++)
      if (gates[k] && !gates_q[k])
        rises[k]++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_fin(input int limit);
    int n;
    n = 0;
    while (finished !== 1'b1 && n < limit)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic start_run(input logic sel);
    i_bbpwm_partner.start(sel);
    cyc(10);
    check("finished low", {7'h0, finished}, 8'h0);
    check("gates in hold", {4'h0, gates}, 8'h0);
    check("code cleared", {5'h0, err_code}, 8'h0);
    cyc(530);
    check("echo", {7'h0, echo}, {7'h0, ~sel});
  endtask

  task automatic stop_wait();
    i_bbpwm_partner.stop();
    wait_fin(3000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_normal(input logic sel);
    int r0;
    int r1;
    int r2;
    int r3;
    int d;
    r0 = rises[sel ? 0 : 1];
    r1 = rises[sel ? 1 : 0];
    r2 = rises[2];
    r3 = rises[3];
    cyc(2000);
    d = rises[sel ? 0 : 1] - r0;
    check("ctrl pulses", {7'h0, d >= 9 && d <= 11}, 8'h1);
    check("rect pulses", {7'h0, rises[sel ? 1 : 0] > r1}, 8'h1);
    check("sync pulses", {7'h0, rises[2] > r2}, 8'h1);
    check("clamp pulses", {7'h0, rises[3] > r3}, 8'h1);
    check("sense invert", {7'h0, sense_inv}, {7'h0, sel});
    check("reference", reference, setpoint);
    i_bbpwm_partner.stop();
    cyc(100);
    check("ramping down", {7'h0, finished}, 8'h0);
    // During ramp-down only the control gate and the clamp may switch.
    r0 = rises[sel ? 0 : 1];
    r1 = rises[sel ? 1 : 0] + rises[2];
    cyc(400);
    check("ctrl in ramp-down", {7'h0, rises[sel ? 0 : 1] > r0}, 8'h1);
    d = rises[sel ? 1 : 0] + rises[2] - r1;
    check("sync idle", {7'h0, d == 0}, 8'h1);
    wait_fin(3000);
    check("finished high", {7'h0, finished}, 8'h1);
    check("no fault", {5'h0, err_code}, 8'h0);
    check("no irq", {7'h0, error_irq}, 8'h0);
    cyc(50);
    check("finished held", {7'h0, finished}, 8'h1);
  endtask

  task automatic set_fault(input bbpwm_err_t code, input logic v);
    case (code)
      3'h6: overvolt <= v;
      3'h5: undervolt <= v;
      default: thermal <= v;
    endcase
  endtask

  task automatic t_fault(input bbpwm_err_t code);
    start_run(1'b1);
    cyc(50);
    set_fault(code, 1'b1);
    cyc(6);
    check("fault stop", {7'h0, finished}, 8'h1);
    check("fault code", {5'h0, err_code}, {5'h0, code});
    set_fault(code, 1'b0);
    cyc(10);
    check("gates off", {4'h0, gates}, 8'h0);
    check("irq", {7'h0, error_irq}, 8'h1);
    check("code read", {5'h0, code_seen}, {5'h0, code});
    cyc(50);
    check("code held", {5'h0, err_code}, {5'h0, code});
    stop_wait();
  endtask

  task automatic t_limit(input logic sec);
    int n;
    n = sec ? 8 : 4;
    start_run(1'b1);
    for (int k = 0; k < n; k++)
    begin
      if (k == n - 1)
        check("below limit", {7'h0, finished}, 8'h0);
      if (sec)
        ilim_sec <= 1'b1;
      else
        ilim_pri <= 1'b1;
      cyc(3);
      ilim_sec <= 1'b0;
      ilim_pri <= 1'b0;
      cyc(3);
    end
    cyc(5);
    check("limit stop", {7'h0, finished}, 8'h1);
    check("limit code", {5'h0, err_code}, sec ? 8'h2 : 8'h1);
    stop_wait();
  endtask

  task automatic t_watchdog();
    start_run(1'b1);
    wait_fin(WD_SIM * 200 + 1000);
    check("wd stop", {7'h0, finished}, 8'h1);
    check("wd code", {5'h0, err_code}, 8'h4);
    cyc(2);
    check("wd irq", {7'h0, error_irq}, 8'h1);
    check("wd code read", {5'h0, code_seen}, 8'h4);
    stop_wait();
  endtask

  task automatic t_undervoltage_lockout();
    int r;
    start_run(1'b0);
    cyc(400);
    undervoltage_lockout_n <= 1'b0;
    cyc(4);
    r = rises[1] + rises[3];
    cyc(400);
    check("lockout gates", {4'h0, gates}, 8'h0);
    check("lockout edges", {7'h0, rises[1] + rises[3] == r}, 8'h1);
    undervoltage_lockout_n <= 1'b1;
    cyc(400);
    check("resumed", {7'h0, rises[1] + rises[3] > r}, 8'h1);
    stop_wait();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    setpoint = 8'h08;
    peak_trip = 1'b0;
    ilim_pri = 1'b0;
    ilim_sec = 1'b0;
    overvolt = 1'b0;
    undervolt = 1'b0;
    thermal = 1'b0;
    undervoltage_lockout_n = 1'b1;
    failures = 0;
    samples_checked = 0;
    cyc(20);
    nrst <= 1'b1;
    cyc(5);
    check("reset finished", {7'h0, finished}, 8'h1);
    check("reset gates", {4'h0, gates}, 8'h0);
    start_run(1'b1);
    check("ref at start", reference, 8'h0);
    t_normal(1'b1);
    start_run(1'b0);
    t_normal(1'b0);
    t_fault(3'h6);
    t_fault(3'h5);
    t_fault(3'h3);
    t_limit(1'b0);
    t_limit(1'b1);
    t_watchdog();
    t_undervoltage_lockout();
    close_out();
  end

  // Whole run is about 25000 cycles; more than twice that means a hang.
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
